// ===== core/fcb_bank.sv
// Functional notes
// - side taps: signed 12 bits in 24, top twelve reserved
// - centre tap: signed 18 bits in 24
// - readback returns coefficient sign bit as zero
// - dual mode: registers feed channel A filter
// - single mode: registers feed merged filter
// - all coefficient registers reset to zero
// - mode 0 bypasses, mode 2 enables filter
`default_nettype none
module fcb_bank
  import fcb_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              reset_n_in,
  input  wire logic              ce_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  input  wire logic              serial_link_enable_in,
  output logic      [DATA_W-1:0] rdata_out,
  output logic                   filter_enable_out,
  output logic                   filter_merge_ctl_out,
  output logic                   coef_share_out,
  output logic      [2:0]        side_coef_weight_out,
  output logic      [7:0]        side_lsb_neg_exp_out,
  output logic      [SIDE_W-1:0] chan_a_tap2_out,
  output logic      [SIDE_W-1:0] chan_a_tap3_out,
  output logic      [SIDE_W-1:0] chan_a_tap4_out,
  output logic      [CTR_W-1:0]  chan_a_center_out,
  output logic      [SIDE_W-1:0] chan_a_tap6_out,
  output logic      [SIDE_W-1:0] merged_tap2_out,
  output logic      [SIDE_W-1:0] merged_tap3_out,
  output logic      [SIDE_W-1:0] merged_tap4_out,
  output logic      [CTR_W-1:0]  merged_center_out,
  output logic      [SIDE_W-1:0] merged_tap6_out
);

  logic [CTR_W-1:0]  coef_r   [NUM_TAPS];
  logic [CTR_W-1:0]  coef_nxt [NUM_TAPS];
  logic [CTR_W-1:0]  coef_rb  [NUM_TAPS];
  logic [1:0]        mode_r;
  logic [1:0]        mode_nxt;
  logic [2:0]        scw_r;
  logic [2:0]        scw_nxt;
  logic              merge_r;
  logic              merge_nxt;
  logic              share_r;
  logic              share_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              cfg_wr;
  logic [2:0]        scw_eff;
  logic              merged;

  assign cfg_wr = ce_in && wr_in && (addr_in == CFG_ADDR);

  // per-tap storage, write decode and readback image
  for (genvar i = 0; i < NUM_TAPS; i++) begin : g_tap
    localparam int W = (i == CTR_IDX) ? CTR_W : SIDE_W;
    logic [CTR_W-1:0] wmask;
    assign wmask = CTR_W'((2 ** W) - 1);
    always_comb begin
      coef_nxt[i] = coef_r[i];
      if (ce_in && wr_in && (addr_in == TAP_ADDR[i])) begin
        coef_nxt[i] = wdata_in[CTR_W-1:0] & wmask;
      end
    end
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        coef_r[i] <= COEF_RST;
      end else begin
        coef_r[i] <= coef_nxt[i];
      end
    end
    // sign bit always reads back as zero
    assign coef_rb[i] = coef_r[i] & (wmask >> 1);
  end

  // configuration register next state
  always_comb begin
    mode_nxt  = mode_r;
    scw_nxt   = scw_r;
    merge_nxt = merge_r;
    share_nxt = share_r;
    if (cfg_wr) begin
      mode_nxt  = wdata_in[MODE_LSB +: 2];
      scw_nxt   = wdata_in[SCW_LSB +: 3];
      merge_nxt = wdata_in[MERGE_BIT];
      share_nxt = wdata_in[SHARE_BIT];
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_r  <= FCB_BYPASS;
      scw_r   <= SCW_RST;
      merge_r <= 1'b0;
      share_r <= 1'b0;
    end else begin
      mode_r  <= mode_nxt;
      scw_r   <= scw_nxt;
      merge_r <= merge_nxt;
      share_r <= share_nxt;
    end
  end

  // read mux, answered one cycle after the strobe
  always_comb begin
    rdata_nxt = '0;
    if (ce_in && rd_in) begin
      if (addr_in == CFG_ADDR) begin
        rdata_nxt[MODE_LSB +: 2] = mode_r;
        rdata_nxt[SCW_LSB +: 3]  = scw_r;
        rdata_nxt[MERGE_BIT]     = merge_r;
        rdata_nxt[SHARE_BIT]     = share_r;
        rdata_nxt[7]             = serial_link_enable_in;
      end
      for (int k = 0; k < NUM_TAPS; k++) begin
        if (addr_in == TAP_ADDR[k]) begin
          rdata_nxt = {{(DATA_W-CTR_W){1'b0}}, coef_rb[k]};
        end
      end
    end else if (!ce_in) begin
      rdata_nxt = rdata_r;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_out = rdata_r;

  // filter controls; reserved modes act as bypass
  assign filter_enable_out    = (mode_r == FCB_ENABLE);
  assign merged               = merge_r;
  assign filter_merge_ctl_out = merged;
  assign coef_share_out       = share_r;
  // weights above the top step are held at the top step
  assign scw_eff              = (scw_r > SCW_MAX) ? SCW_MAX : scw_r;
  assign side_coef_weight_out = scw_eff;
  assign side_lsb_neg_exp_out = SCW_BASE - {5'h0, scw_eff};

  // route coefficients to channel A filter or merged filter
  assign chan_a_tap2_out   = merged ? '0 : coef_r[0][SIDE_W-1:0];
  assign chan_a_tap3_out   = merged ? '0 : coef_r[1][SIDE_W-1:0];
  assign chan_a_center_out = merged ? '0 : coef_r[CTR_IDX];
  assign chan_a_tap4_out   = merged ? '0 : coef_r[2][SIDE_W-1:0];
  assign chan_a_tap6_out   = merged ? '0 : coef_r[4][SIDE_W-1:0];
  assign merged_tap2_out   = merged ? coef_r[0][SIDE_W-1:0] : '0;
  assign merged_tap3_out   = merged ? coef_r[1][SIDE_W-1:0] : '0;
  assign merged_center_out = merged ? coef_r[CTR_IDX] : '0;
  assign merged_tap4_out   = merged ? coef_r[2][SIDE_W-1:0] : '0;
  assign merged_tap6_out   = merged ? coef_r[4][SIDE_W-1:0] : '0;

endmodule
`default_nettype wire

// ===== core/fcb_pkg.sv
`default_nettype none
package fcb_pkg;
  // register port geometry
  localparam int ADDR_W   = 11;
  localparam int DATA_W   = 24;
  // coefficient widths
  localparam int SIDE_W   = 12;
  localparam int CTR_W    = 18;
  localparam int NUM_TAPS = 5;
  // index of the centre tap in the tap array (taps 2..6 -> 0..4)
  localparam int CTR_IDX  = 3;
  // register offsets
  localparam logic [ADDR_W-1:0] CFG_ADDR  = 11'h400;
  localparam logic [ADDR_W-1:0] TAP2_ADDR = 11'h41a;
  localparam logic [ADDR_W-1:0] TAP3_ADDR = 11'h41c;
  localparam logic [ADDR_W-1:0] TAP4_ADDR = 11'h41e;
  localparam logic [ADDR_W-1:0] CTR_ADDR  = 11'h420;
  localparam logic [ADDR_W-1:0] TAP6_ADDR = 11'h423;
  localparam logic [NUM_TAPS-1:0][ADDR_W-1:0] TAP_ADDR =
    {TAP6_ADDR, CTR_ADDR, TAP4_ADDR, TAP3_ADDR, TAP2_ADDR};
  // config field positions
  localparam int MODE_LSB  = 0;
  localparam int SCW_LSB   = 2;
  localparam int MERGE_BIT = 5;
  localparam int SHARE_BIT = 6;
  // reset values and limits
  localparam logic [CTR_W-1:0] COEF_RST = 18'h0;
  localparam logic [2:0]       SCW_RST  = 3'h0;
  localparam logic [2:0]       SCW_MAX  = 3'h6;
  localparam logic [7:0]       SCW_BASE = 8'h10;
  // filter mode encodings
  typedef enum logic [1:0] {
    FCB_BYPASS = 2'b00,
    FCB_RSVD1  = 2'b01,
    FCB_ENABLE = 2'b10,
    FCB_RSVD3  = 2'b11
  } fcb_mode_e;
endpackage
`default_nettype wire

// ===== tb/fcb_bank_props.sv
`default_nettype none
module fcb_props
  import fcb_pkg::*;
(
  input wire logic              mclk_in, reset_n_in, ce_in, wr_in, rd_in,
  input wire logic              filter_enable_out, filter_merge_ctl_out,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in, rdata_out,
  input wire logic [2:0]        side_coef_weight_out,
  input wire logic [7:0]        side_lsb_neg_exp_out,
  input wire logic [SIDE_W-1:0] chan_a_tap3_out, chan_a_tap4_out, chan_a_tap6_out,
  input wire logic [SIDE_W-1:0] merged_tap2_out, merged_tap3_out, merged_tap6_out,
  input wire logic [CTR_W-1:0]  chan_a_center_out, merged_center_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // readback and storage relations
  chk_side_rd_msb: assert property (ce_in && rd_in && addr_in != CTR_ADDR
    |=> rdata_out[23:11] == 0) else $error("side readback msb set");
  chk_ctr_rd_msb: assert property (ce_in && rd_in && addr_in == CTR_ADDR
    |=> rdata_out[23:17] == 0) else $error("centre readback msb set");
  chk_tap3_store: assert property (ce_in && wr_in && addr_in == TAP3_ADDR
    |=> (chan_a_tap3_out | merged_tap3_out) == $past(wdata_in[11:0]))
    else $error("tap3 not stored");
  chk_ctr_store: assert property (ce_in && wr_in && addr_in == CTR_ADDR
    |=> (chan_a_center_out | merged_center_out) == $past(wdata_in[17:0]))
    else $error("centre not stored");
  // routing between dual and merged filters, mode decode, side weight clamp and tap6 reset
  chk_dual_route: assert property (!filter_merge_ctl_out
    |-> merged_center_out == 0 && merged_tap2_out == 0) else $error("merged side live");
  chk_merge_route: assert property (filter_merge_ctl_out
    |-> chan_a_center_out == 0 && chan_a_tap4_out == 0) else $error("channel side live");
  chk_mode_enable: assert property (ce_in && wr_in && addr_in == CFG_ADDR
    |=> filter_enable_out == ($past(wdata_in[1:0]) == 2'h2)) else $error("mode decode");
  chk_side_weight: assert property (side_coef_weight_out <= 3'h6
    && side_lsb_neg_exp_out == 8'h10 - side_coef_weight_out) else $error("lsb weight");
  chk_tap6_reset: assert property ($rose(reset_n_in)
    |-> chan_a_tap6_out == 0 && merged_tap6_out == 0) else $error("tap6 reset");
endmodule
bind fcb_bank fcb_props chk_u (.*);
`default_nettype wire

// ===== tb/tb_top.sv
`default_nettype none
module tb_top import fcb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 0, reset_n_in = 0, wr_in = 0, rd_in = 0, fe, mg, sh;
  logic [10:0] addr_in = 0;
  logic [23:0] wdata_in = 0, rdata_out;
  logic ce = 1, lk = 0;
  logic [2:0] w;
  logic [7:0] ex;
  logic [11:0] c2, c3, c4, c6, m2, m3, m4, m6;
  logic [17:0] cc, mc;
  int errors = 0, n_tests = 0;
  logic [10:0] ra[5] = '{TAP2_ADDR, TAP3_ADDR, TAP4_ADDR, CTR_ADDR, TAP6_ADDR};
  logic [23:0] rw[5] = '{24'hfff, 24'hfff800, 24'h123, 24'h3ffff, 24'ha5a};
  logic [23:0] rr[5] = '{24'h7ff, 24'h0, 24'h123, 24'h1ffff, 24'h25a};
  fcb_bank dut_u (.mclk_in, .reset_n_in, .ce_in(ce), .addr_in, .wdata_in, .wr_in, .rd_in,
    .serial_link_enable_in(lk), .rdata_out, .filter_enable_out(fe),
    .filter_merge_ctl_out(mg), .coef_share_out(sh), .side_coef_weight_out(w),
    .side_lsb_neg_exp_out(ex), .chan_a_tap2_out(c2), .chan_a_tap3_out(c3),
    .chan_a_tap4_out(c4), .chan_a_center_out(cc), .chan_a_tap6_out(c6),
    .merged_tap2_out(m2), .merged_tap3_out(m3), .merged_tap4_out(m4),
    .merged_center_out(mc), .merged_tap6_out(m6));
  initial forever #25 mclk_in = ~mclk_in;
  task automatic chk(input logic [65:0] got, input logic [65:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one-cycle bus strobes
  task automatic wr(input logic [10:0] a, input logic [23:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [10:0] a, input logic [23:0] e);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, e);
  endtask
  task automatic test_done;
    if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    test_done;
  end
  // table pass, then routing, modes, unmapped and reset
  initial begin
    repeat (8) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(ra[i], rw[i]);
      rd(ra[i], rr[i]);
    end
    chk({c2, c3, c4, cc, c6}, {36'hfff800123, 18'h3ffff, 12'ha5a});
    wr(CFG_ADDR, 24'h3a);
    chk({m2, m3, m4, mc, m6}, {36'hfff800123, 18'h3ffff, 12'ha5a});
    chk({fe, mg, ex, cc, c6}, {1'b1, 1'b1, 8'h0a, 30'h0});
    for (int m = 0; m < 4; m++) begin
      wr(CFG_ADDR, 24'(m));
      chk(fe, m == 2);
    end
    wr(CFG_ADDR, 24'h1c);
    chk({w, ex}, {3'h6, 8'h0a});
    rd(11'h500, 24'h0);
    // config written with link off, then link status mirrored on readback
    wr(CFG_ADDR, 24'h40);
    chk({sh, mg}, 2'b10);
    @(posedge mclk_in);
    lk <= 1'b1;
    rd(CFG_ADDR, 24'hc0);
    @(posedge mclk_in);
    lk <= 1'b0;
    #1 chk(rdata_out, 24'h0);
    // clock enable low: write strobe ignored
    @(posedge mclk_in);
    ce <= 1'b0;
    addr_in <= TAP3_ADDR;
    wdata_in <= 24'h111;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    ce <= 1'b1;
    #1 chk(c3, 12'h800);
    @(posedge mclk_in);
    reset_n_in <= 1'b0;
    @(posedge mclk_in);
    reset_n_in <= 1'b1;
    rd(TAP6_ADDR, 24'h0);
    chk({c2, cc, m6}, 0);
    test_done;
  end
endmodule
`default_nettype wire
